// ---- hw/iwc_pkg.sv ----
// shared constants for the word checksum link
// assumes: both ends run on one 50 MHz clock
package iwc_pkg;
  localparam int          IWC_DATA_W   = 16;
  localparam int          IWC_BYTE_W   = 8;
  localparam logic [7:0]  IWC_POLY     = 8'h31;
  localparam logic [7:0]  IWC_INIT     = 8'hff;
  localparam logic [7:0]  IWC_FINAL    = 8'h00;
  localparam int          IWC_BYTE_HI  = 8;
  localparam logic [15:0] IWC_REF_WORD = 16'hbeef;
  localparam logic [7:0]  IWC_REF_CRC  = 8'h92;

  typedef enum logic [1:0] {
    IWC_IDLE = 2'b00,
    IWC_HI   = 2'b01,
    IWC_LO   = 2'b11,
    IWC_CRC  = 2'b10
  } iwc_phase_t;

  // crc of one byte, msb first, no reflection
  function automatic logic [7:0] iwc_crc_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < IWC_BYTE_W; i++) begin
      c = c[7] ? ((c << 1) ^ IWC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // crc over one 16-bit word, preset fresh every call
  function automatic logic [7:0] iwc_crc_word(input logic [15:0] word);
    logic [7:0] c;
    c = iwc_crc_byte(IWC_INIT, word[15:IWC_BYTE_HI]);
    c = iwc_crc_byte(c, word[IWC_BYTE_HI-1:0]);
    return c ^ IWC_FINAL;
  endfunction
endpackage

// ---- hw/iwc_link_if.sv ----
// byte stream between the two ends: word high byte, low byte, checksum
// assumes: one shared clock; each end owns its own transmit lane
interface iwc_link_if;
  logic [7:0] devByte;   // device to host byte
  logic       devValid;  // device byte strobe
  logic [7:0] hostByte;  // host to device byte
  logic       hostValid; // host byte strobe

  modport dev  (output devByte, output devValid, input hostByte, input hostValid);
  modport host (output hostByte, output hostValid, input devByte, input devValid);
endinterface

// ---- hw/iwc_dev_end.sv ----
// sensor end: sends read words with checksum, checks received write words
// assumes: link strobes are from logic on the same clock
//
// Functional notes
// - every sent word followed by checksum byte
// - checksum over the word's two bytes only
// - crc8 poly 31, preset ff, xor 00
// - same checksum both directions; beef gives 92
// - word sent high byte first
module iwc_dev_end
  import iwc_pkg::*;
(
  input  wire logic             clock,     // 50 MHz clock
  input  wire logic             rst,       // async reset, active high
  iwc_link_if.dev               link,      // link to the host end
  input  wire logic [15:0]      txWord,    // word to send
  input  wire logic             txStart,   // pulse: send txWord
  output logic                  txBusy,    // sending in progress
  output logic [15:0]           rxWord,    // last received word
  output logic                  rxValid,   // pulse: word received
  output logic                  rxCrcErr   // with rxValid: checksum mismatch
);
  import iwc_pkg::*;

  // ==========================================================
  // transmit
  iwc_phase_t  txPhase_reg;
  logic [15:0] txHold_reg;
  logic [7:0]  txByte_reg;
  logic        txValid_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txPhase_reg <= IWC_IDLE;
      txHold_reg  <= '0;
      txByte_reg  <= '0;
      txValid_reg <= 1'b0;
    end else begin
      txValid_reg <= 1'b0;
      case (txPhase_reg)
        IWC_IDLE: begin
          if (txStart) begin
            txHold_reg  <= txWord;
            txByte_reg  <= txWord[15:IWC_BYTE_HI];
            txValid_reg <= 1'b1;
            txPhase_reg <= IWC_HI;
          end
        end
        IWC_HI: begin
          txByte_reg  <= txHold_reg[IWC_BYTE_HI-1:0];
          txValid_reg <= 1'b1;
          txPhase_reg <= IWC_LO;
        end
        IWC_LO: begin
          txByte_reg  <= iwc_crc_word(txHold_reg);
          txValid_reg <= 1'b1;
          txPhase_reg <= IWC_CRC;
        end
        IWC_CRC: txPhase_reg <= IWC_IDLE;
        default: txPhase_reg <= IWC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) txBusy <= 1'b0;
    else txBusy <= (txPhase_reg == IWC_IDLE) ? txStart : (txPhase_reg != IWC_CRC);
  end

  assign link.devByte  = txByte_reg;
  assign link.devValid = txValid_reg;

  // ==========================================================
  // receive
  logic [1:0]  rxCnt_reg;
  logic [15:0] rxAcc_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxCnt_reg <= '0;
      rxAcc_reg <= '0;
      rxWord    <= '0;
      rxValid   <= 1'b0;
      rxCrcErr  <= 1'b0;
    end else begin
      rxValid  <= 1'b0;
      rxCrcErr <= 1'b0;
      if (link.hostValid) begin
        if (rxCnt_reg == 2'd2) begin
          rxCnt_reg <= '0;
          rxWord    <= rxAcc_reg;
          rxValid   <= 1'b1;
          rxCrcErr  <= (iwc_crc_word(rxAcc_reg) != link.hostByte);
        end else begin
          rxCnt_reg <= rxCnt_reg + 2'd1;
          rxAcc_reg <= {rxAcc_reg[IWC_BYTE_HI-1:0], link.hostByte};
        end
      end
    end
  end
endmodule

// ---- hw/iwc_host_end.sv ----
// host end: sends write words with checksum, checks received read words
// assumes: link strobes are from logic on the same clock
module iwc_host_end
  import iwc_pkg::*;
(
  input  wire logic             clock,     // 50 MHz clock
  input  wire logic             rst,       // async reset, active high
  iwc_link_if.host              link,      // link to the device end
  input  wire logic [15:0]      txWord,    // word to send
  input  wire logic             txStart,   // pulse: send txWord
  output logic                  txBusy,    // sending in progress
  output logic [15:0]           rxWord,    // last received word
  output logic                  rxValid,   // pulse: word received
  output logic                  rxCrcErr   // with rxValid: checksum mismatch
);
  import iwc_pkg::*;

  // ==========================================================
  // transmit
  iwc_phase_t  txPhase_reg;
  logic [15:0] txHold_reg;
  logic [7:0]  txByte_reg;
  logic        txValid_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txPhase_reg <= IWC_IDLE;
      txHold_reg  <= '0;
      txByte_reg  <= '0;
      txValid_reg <= 1'b0;
    end else begin
      txValid_reg <= 1'b0;
      case (txPhase_reg)
        IWC_IDLE: begin
          if (txStart) begin
            txHold_reg  <= txWord;
            txByte_reg  <= txWord[15:IWC_BYTE_HI];
            txValid_reg <= 1'b1;
            txPhase_reg <= IWC_HI;
          end
        end
        IWC_HI: begin
          txByte_reg  <= txHold_reg[IWC_BYTE_HI-1:0];
          txValid_reg <= 1'b1;
          txPhase_reg <= IWC_LO;
        end
        IWC_LO: begin
          txByte_reg  <= iwc_crc_word(txHold_reg);
          txValid_reg <= 1'b1;
          txPhase_reg <= IWC_CRC;
        end
        IWC_CRC: txPhase_reg <= IWC_IDLE;
        default: txPhase_reg <= IWC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) txBusy <= 1'b0;
    else txBusy <= (txPhase_reg == IWC_IDLE) ? txStart : (txPhase_reg != IWC_CRC);
  end

  assign link.hostByte  = txByte_reg;
  assign link.hostValid = txValid_reg;

  // ==========================================================
  // receive
  logic [1:0]  rxCnt_reg;
  logic [15:0] rxAcc_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxCnt_reg <= '0;
      rxAcc_reg <= '0;
      rxWord    <= '0;
      rxValid   <= 1'b0;
      rxCrcErr  <= 1'b0;
    end else begin
      rxValid  <= 1'b0;
      rxCrcErr <= 1'b0;
      if (link.devValid) begin
        if (rxCnt_reg == 2'd2) begin
          rxCnt_reg <= '0;
          rxWord    <= rxAcc_reg;
          rxValid   <= 1'b1;
          rxCrcErr  <= (iwc_crc_word(rxAcc_reg) != link.devByte);
        end else begin
          rxCnt_reg <= rxCnt_reg + 2'd1;
          rxAcc_reg <= {rxAcc_reg[IWC_BYTE_HI-1:0], link.devByte};
        end
      end
    end
  end
endmodule

// ---- sim/iwc_link_properties.sv ----
// lane checks for the word checksum link
// assumes: instantiated in the bench beside the link interface
module iwc_link_properties (
  input wire logic       clock,     // clock
  input wire logic       rst,       // reset
  input wire logic [7:0] devByte,   // dev lane byte
  input wire logic       devValid,  // dev lane strobe
  input wire logic [7:0] hostByte,  // host lane byte
  input wire logic       hostValid  // host lane strobe
);
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  // ====================
  // frame and checksum
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_dev_frame: assert property ($rose(devValid) |-> devValid[*3] ##1 !devValid)
    else $error("dev frame length");
  chk_host_frame: assert property ($rose(hostValid) |-> hostValid[*3] ##1 !hostValid)
    else $error("host frame length");
  chk_dev_crc: assert property ($rose(devValid) |-> ##2
    devByte == crc8({$past(devByte, 2), $past(devByte)})) else $error("dev checksum");
  chk_host_crc: assert property ($rose(hostValid) |-> ##2
    hostByte == crc8({$past(hostByte, 2), $past(hostByte)})) else $error("host checksum");
  chk_dev_restart: assert property (devValid[*3] |=> !devValid)
    else $error("dev frame overrun");
  chk_host_restart: assert property (hostValid[*3] |=> !hostValid)
    else $error("host frame overrun");
endmodule

// ---- sim/tb.sv ----
// bench: both link ends back to back, plus a host end and a device end each fed by a faulty lane
// assumes: package and link interface compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iwc_pkg::*;
  logic        clock = 0, rst = 1, dGo = 0, hGo = 0;
  logic [15:0] dTx = 0, hTx = 0, dRx, hRx, fRx, gRx;
  logic        dBusy, hBusy, dVal, hVal, fVal, dErr, hErr, fErr, gVal, gErr;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  iwc_link_if link ();
  iwc_link_if bad ();
  iwc_link_if badH ();
  iwc_dev_end iwc_dev_end_i (.clock(clock), .rst(rst), .link(link), .txWord(dTx),
    .txStart(dGo), .txBusy(dBusy), .rxWord(dRx), .rxValid(dVal), .rxCrcErr(dErr));
  iwc_host_end iwc_host_end_i (.clock(clock), .rst(rst), .link(link), .txWord(hTx),
    .txStart(hGo), .txBusy(hBusy), .rxWord(hRx), .rxValid(hVal), .rxCrcErr(hErr));
  iwc_host_end iwc_host_end_f (.clock(clock), .rst(rst), .link(bad), .txWord(16'h0000),
    .txStart(1'b0), .txBusy(), .rxWord(fRx), .rxValid(fVal), .rxCrcErr(fErr));
  iwc_dev_end iwc_dev_end_f (.clock(clock), .rst(rst), .link(badH), .txWord(16'h0000),
    .txStart(1'b0), .txBusy(), .rxWord(gRx), .rxValid(gVal), .rxCrcErr(gErr));
  iwc_link_properties iwc_link_properties_i (.clock(clock), .rst(rst),
    .devByte(link.devByte), .devValid(link.devValid),
    .hostByte(link.hostByte), .hostValid(link.hostValid));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      finish_test();
    end
  end
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  function automatic logic [8:0] lane(input bit d);
    return d ? {link.devValid, link.devByte} : {link.hostValid, link.hostByte};
  endfunction
  task check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // ====================
  // transfers
  task xfer(input bit up, input logic [15:0] w, input bit poke);
    @(negedge clock);
    dTx = w;
    hTx = w;
    dGo = up;
    hGo = !up;
    @(negedge clock);
    dGo = 0;
    hGo = 0;
    check("hi", lane(up), {1'b1, w[15:8]});
    check("busy", up ? dBusy : hBusy, 1);
    @(negedge clock);
    check("lo", lane(up), {1'b1, w[7:0]});
    dTx = ~w;
    hTx = ~w;
    dGo = poke & up;
    hGo = poke & !up;
    @(negedge clock);
    dGo = 0;
    hGo = 0;
    check("crc", lane(up), {1'b1, crc8(w)});
    @(negedge clock);
    check("rx", up ? {hVal, hErr, hRx} : {dVal, dErr, dRx}, {2'b10, w});
    check("busy", up ? dBusy : hBusy, 0);
    @(negedge clock);
    check("idle", lane(up) >> 8, 0);
  endtask
  task drive_bad(input bit up, input bit v, input logic [7:0] b);
    if (up) begin
      bad.devValid = v;
      bad.devByte = b;
    end else begin
      badH.hostValid = v;
      badH.hostByte = b;
    end
  endtask
  task inject(input bit up, input logic [15:0] w, input logic [7:0] flip);
    @(negedge clock);
    drive_bad(up, 1, w[15:8]);
    @(negedge clock);
    drive_bad(up, 1, w[7:0]);
    @(negedge clock);
    drive_bad(up, 1, crc8(w) ^ flip);
    @(negedge clock);
    drive_bad(up, 0, ~w[7:0]);
    check("flag", up ? {fVal, fErr, fRx} : {gVal, gErr, gRx}, {1'b1, flip != 0, w});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    bad.devValid = 0;
    bad.devByte = 0;
    badH.hostValid = 0;
    badH.hostByte = 0;
    void'($urandom(24));
    repeat (8) @(posedge clock);
    @(negedge clock) rst = 0;
    check("ref", crc8(16'hbeef), 8'h92);
    xfer(1, 16'hbeef, 0);
    xfer(0, 16'hbeef, 1);
    xfer(1, 16'h0000, 1);
    xfer(0, 16'hffff, 0);
    repeat (20) xfer(1'($urandom), 16'($urandom), 1'($urandom));
    inject(1, 16'hbeef, 8'h00);
    inject(0, 16'hbeef, 8'h00);
    for (int i = 0; i < 8; i++) inject(1, 16'($urandom), 8'(8'h01 << i));
    for (int i = 0; i < 8; i++) inject(0, 16'($urandom), 8'(8'h01 << i));
    finish_test();
  end
endmodule
